//--- design/mailbox_pkg.sv
// Shared constants and types for the dual-port mailbox bypass block.
// Summary of operation
// RULE_01: Two independent 36-bit mailboxes, one each way, bypass the FIFO.
// RULE_02: Per-port mailbox select high picks the mailbox, low picks the FIFO.
// RULE_03: Port A clock rise with port A mailbox write stores port A data.
// RULE_04: Port B clock rise with port B mailbox write stores port B data.
// RULE_05: Accepted write drives that mailbox's active-low full flag low.
// RULE_06: Writes to a mailbox whose full flag is low are discarded.
// RULE_07: Port B data shows FIFO output if select low, A-to-B mail if high.
// RULE_08: Port A data always shows the B-to-A mailbox when driven.
// RULE_09: Port B mailbox read sets the A-to-B full flag high.
// RULE_10: Port A mailbox read sets the B-to-A full flag high.
// RULE_11: Reading never alters a mailbox; only accepted writes change it.
// RULE_12: Data pins drive only for a selected read direction, else released.
// RULE_13: Host pulses select and enable for one edge and checks full first; the bench holds select, pulses only enable and writes without checking full.
// RULE_14: After reset both full flags read high so first writes succeed.
package mailbox_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          MAIL_W       = 36;
    localparam int          SYNC_STAGES  = 3;
    localparam logic        FULL_N_RESET = 1'h1;
    localparam logic [35:0] MAIL_RESET   = 36'h0_0000_0000;

    // ------------------------------------------------------------------
    // Port control and data sampled from one side's pins
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              cs_n;
        logic              wr_rd;
        logic              en;
        logic              mb;
        logic [MAIL_W-1:0] data;
    } port_in_t;

    localparam int PORT_IN_W = MAIL_W + 4;

endpackage

//--- design/port_edge_sampler.sv
// Samples one port's clock and control pins into the reference clock domain.
`timescale 1ns/100ps
module port_edge_sampler (
    // Reference clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    // Pins of one port
    input  wire logic                 i_port_clk,
    input  wire mailbox_pkg::port_in_t i_port,
    // Sampled view
    output logic                      o_rise,
    output mailbox_pkg::port_in_t     o_port
);
    import mailbox_pkg::*;

    logic [SYNC_STAGES-1:0] clk_sync_q;
    logic                   clk_filt_q;
    logic                   clk_filt_d;
    logic                   clk_agree;
    port_in_t               bus_sync_q [SYNC_STAGES];

    // ------------------------------------------------------------------
    // Clock level filter
    // ------------------------------------------------------------------
    // The level counts only once the second and third stages agree.
    assign clk_agree  = clk_sync_q[1] == clk_sync_q[2];
    assign clk_filt_d = clk_agree ? clk_sync_q[2] : clk_filt_q;
    assign o_rise     = clk_agree & clk_sync_q[2] & ~clk_filt_q;
    assign o_port     = bus_sync_q[SYNC_STAGES-1];

    // Three-stage shift of the clock pin; stage zero feeds only stage one.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            clk_sync_q <= '1;
            clk_filt_q <= 1'h1;    // A clock already high is no edge.
        end else begin
            clk_sync_q <= {clk_sync_q[SYNC_STAGES-2:0], i_port_clk};
            clk_filt_q <= clk_filt_d;
        end
    end

    // Controls and data travel the same depth so they line up with the edge.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                bus_sync_q[i] <= '{cs_n: 1'h1, default: '0};
            end
        end else begin
            bus_sync_q[0] <= i_port;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                bus_sync_q[i] <= bus_sync_q[i-1];
            end
        end
    end

endmodule

//--- design/dual_port_mailbox_bypass.sv
// Two mailbox bypass registers between port A and port B, with full flags.
`timescale 1ns/100ps
module dual_port_mailbox_bypass (
    // Reference clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst,
    // Port A pins
    input  wire logic                     i_port_a_clock,
    input  wire mailbox_pkg::port_in_t    i_port_a,
    output logic [mailbox_pkg::MAIL_W-1:0] o_port_a_data_bus,
    output logic                          o_port_a_data_oe,
    output logic                          o_b_to_a_mail_full_n,
    // Port B pins
    input  wire logic                     i_port_b_clock,
    input  wire mailbox_pkg::port_in_t    i_port_b,
    output logic [mailbox_pkg::MAIL_W-1:0] o_port_b_data_bus,
    output logic                          o_port_b_data_oe,
    output logic                          o_a_to_b_mail_full_n,
    // FIFO output register word offered to port B
    input  wire logic [mailbox_pkg::MAIL_W-1:0] i_fifo_out_data
);
    import mailbox_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic              a_rise;
    logic              b_rise;
    port_in_t          a_s;
    port_in_t          b_s;
    logic [MAIL_W-1:0] a_to_b_mailbox_q;
    logic [MAIL_W-1:0] b_to_a_mailbox_q;
    logic              a_to_b_full_n_q;
    logic              a_to_b_full_n_d;
    logic              b_to_a_full_n_q;
    logic              b_to_a_full_n_d;
    logic [MAIL_W-1:0] a_data_q;
    logic [MAIL_W-1:0] b_data_q;
    logic [MAIL_W-1:0] b_data_d;
    logic              a_sel;
    logic              b_sel;
    logic              a_mb_wr;
    logic              a_mb_rd;
    logic              b_mb_wr;
    logic              b_mb_rd;
    logic              a_wr_ok;
    logic              b_wr_ok;

    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    // Each port clock is a pin, so its edges are found in the reference domain.
    port_edge_sampler u_port_a (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_port_clk (i_port_a_clock),
        .i_port     (i_port_a),
        .o_rise     (a_rise),
        .o_port     (a_s)
    );

    port_edge_sampler u_port_b (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_port_clk (i_port_b_clock),
        .i_port     (i_port_b),
        .o_rise     (b_rise),
        .o_port     (b_s)
    );

    // ------------------------------------------------------------------
    // Transfer decode
    // ------------------------------------------------------------------
    // A selected transfer needs chip select low and enable high on an edge.
    assign a_sel   = a_rise & ~a_s.cs_n & a_s.en;
    assign b_sel   = b_rise & ~b_s.cs_n & b_s.en;
    // Port A writes with direction high; port B writes with direction low.
    assign a_mb_wr = a_sel & a_s.wr_rd & a_s.mb;   // RULE_02
    assign a_mb_rd = a_sel & ~a_s.wr_rd & a_s.mb;  // RULE_02
    assign b_mb_wr = b_sel & ~b_s.wr_rd & b_s.mb;  // RULE_02
    assign b_mb_rd = b_sel & b_s.wr_rd & b_s.mb;   // RULE_02
    // A write lands only while its mailbox shows empty.
    assign a_wr_ok = a_mb_wr & a_to_b_full_n_q;    // RULE_06
    assign b_wr_ok = b_mb_wr & b_to_a_full_n_q;    // RULE_06

    // ------------------------------------------------------------------
    // Full flags
    // ------------------------------------------------------------------
    // A write in the same cycle as the consuming read wins, so mail is kept.
    assign a_to_b_full_n_d = a_wr_ok ? 1'h0 :      // RULE_05
                             b_mb_rd ? 1'h1 :      // RULE_09
                             a_to_b_full_n_q;
    assign b_to_a_full_n_d = b_wr_ok ? 1'h0 :      // RULE_05
                             a_mb_rd ? 1'h1 :      // RULE_10
                             b_to_a_full_n_q;

    // Flags come up empty so the first write from either side is accepted.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            a_to_b_full_n_q <= FULL_N_RESET;       // RULE_14
            b_to_a_full_n_q <= FULL_N_RESET;       // RULE_14
        end else begin
            a_to_b_full_n_q <= a_to_b_full_n_d;
            b_to_a_full_n_q <= b_to_a_full_n_d;
        end
    end

    // ------------------------------------------------------------------
    // Mail storage
    // ------------------------------------------------------------------
    // Each mailbox loads only on an accepted write; reads leave it intact.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            a_to_b_mailbox_q <= MAIL_RESET;
            b_to_a_mailbox_q <= MAIL_RESET;
        end else begin
            if (a_wr_ok) begin
                a_to_b_mailbox_q <= a_s.data;      // RULE_03 RULE_01 RULE_11
            end
            if (b_wr_ok) begin
                b_to_a_mailbox_q <= b_s.data;      // RULE_04 RULE_01 RULE_11
            end
        end
    end

    // ------------------------------------------------------------------
    // Output data paths
    // ------------------------------------------------------------------
    // Port B selects between the FIFO output word and the A-to-B mail.
    assign b_data_d = b_s.mb ? a_to_b_mailbox_q : i_fifo_out_data; // RULE_07

    // Data outputs are registered so they settle cleanly toward the pins.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            a_data_q <= MAIL_RESET;
            b_data_q <= MAIL_RESET;
        end else begin
            a_data_q <= b_to_a_mailbox_q;          // RULE_08
            b_data_q <= b_data_d;                  // RULE_07
        end
    end

    // Drive enables follow the sampled chip select and direction levels.
    assign o_port_a_data_oe     = ~a_s.cs_n & ~a_s.wr_rd;  // RULE_12
    assign o_port_b_data_oe     = ~b_s.cs_n & b_s.wr_rd;   // RULE_12
    assign o_port_a_data_bus    = a_data_q;
    assign o_port_b_data_bus    = b_data_q;
    assign o_a_to_b_mail_full_n = a_to_b_full_n_q;
    assign o_b_to_a_mail_full_n = b_to_a_full_n_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // An accepted port A write shows in the mailbox and flag one cycle on.
    a_write_store_a: assert property (   // RULE_03
        a_wr_ok |=> a_to_b_mailbox_q == $past(a_s.data)
                    && !o_a_to_b_mail_full_n)
        else $error("A-to-B mailbox did not take the port A word.");

    // An accepted port B write shows in the mailbox and flag one cycle on.
    b_write_store_a: assert property (   // RULE_04
        b_wr_ok |=> b_to_a_mailbox_q == $past(b_s.data)
                    && !o_b_to_a_mail_full_n)
        else $error("B-to-A mailbox did not take the port B word.");

    // The A-to-B flag only falls on the cycle after a port A mailbox write.
    full_fall_cause_a: assert property ( // RULE_05
        $fell(o_a_to_b_mail_full_n) |-> $past(a_mb_wr))
        else $error("A-to-B full flag fell without a port A write.");

    // A write into a full mailbox that no read frees changes nothing.
    full_refuse_a: assert property (     // RULE_06
        (a_mb_wr && !o_a_to_b_mail_full_n && !b_mb_rd) |=>
            $stable(a_to_b_mailbox_q) && !o_a_to_b_mail_full_n)
        else $error("Write into a full A-to-B mailbox was not discarded.");

    // Port B output follows the select one cycle later.
    b_out_mux_a: assert property (       // RULE_07
        ##1 o_port_b_data_bus == ($past(b_s.mb) ? $past(a_to_b_mailbox_q)
                                                : $past(i_fifo_out_data)))
        else $error("Port B data came from the wrong source.");

    // Port A output mirrors the B-to-A mailbox whatever the selects do.
    a_out_mail_a: assert property (      // RULE_08
        1'b1 |=> o_port_a_data_bus == $past(b_to_a_mailbox_q))
        else $error("Port A data does not show the B-to-A mailbox.");

    // A port B mailbox read empties the A-to-B flag unless a write lands.
    b_read_clear_a: assert property (    // RULE_09
        (b_mb_rd && !a_wr_ok) |=> o_a_to_b_mail_full_n)
        else $error("Port B mailbox read left the A-to-B flag low.");

    // A port A mailbox read empties the B-to-A flag unless a write lands.
    a_read_clear_a: assert property (    // RULE_10
        (a_mb_rd && !b_wr_ok) |=> o_b_to_a_mail_full_n)
        else $error("Port A mailbox read left the B-to-A flag low.");

    // Without an accepted write the stored words never move.
    mail_hold_a: assert property (       // RULE_11
        !a_wr_ok && !b_wr_ok |=> $stable(a_to_b_mailbox_q)
                                 && $stable(b_to_a_mailbox_q))
        else $error("Mailbox word changed without an accepted write.");

    // Neither port drives its data pins while it is deselected.
    drive_deselect_a: assert property (  // RULE_12
        (a_s.cs_n |-> !o_port_a_data_oe) and
        (b_s.cs_n |-> !o_port_b_data_oe))
        else $error("Data pins driven while chip select is high.");

    // Reset leaves both flags high on the first cycle after it.
    reset_empty_a: assert property (     // RULE_14
        @(posedge i_ref_clk) disable iff (1'b0)
        i_rst |=> o_a_to_b_mail_full_n && o_b_to_a_mail_full_n)
        else $error("Full flags not high after reset.");

    // Main scenarios.
    a_mail_sent_c:   cover property (a_wr_ok ##[1:300] b_mb_rd);
    b_mail_sent_c:   cover property (b_wr_ok ##[1:300] a_mb_rd);
    write_refused_c: cover property (a_mb_wr && !o_a_to_b_mail_full_n);
    fifo_path_c:     cover property (o_port_b_data_oe && !b_s.mb);

endmodule

//--- design/unused_placeholder_none.sv
// Intentionally empty file kept for compile order.
`timescale 1ns/100ps

//--- sim/mailbox_host_model.sv
// Host model that clocks one port of the mailbox block and drives its pins.
`timescale 1ns/100ps
module mailbox_host_model #(
    parameter real HALF_NS = 20.0
) (
    // Reference clock
    input  wire logic                  i_ref_clk,
    // Port pins
    output logic                       o_port_clk,
    output mailbox_pkg::port_in_t      o_port
);
    import mailbox_pkg::*;

    // Free-running port clock whose phase is unrelated to the reference.
    initial begin
        o_port_clk = 1'h0;
        o_port     = '{1'h1, 1'h0, 1'h0, 1'h0, MAIL_RESET};
        #(HALF_NS / 3.0);
        forever #(HALF_NS) o_port_clk = ~o_port_clk;
    end

    // Pins change only after a falling port clock, so each level is held
    // across at least one rising edge with its whole sampling window.
    task automatic set_pins(input port_in_t p);
        @(negedge o_port_clk);
        @(negedge i_ref_clk);
        o_port = p;
    endtask
endmodule

//--- sim/dual_port_mailbox_bypass_tb_top.sv
// Self-checking bench for the dual-port mailbox bypass block.
`timescale 1ns/100ps
module dual_port_mailbox_bypass_tb_top;
    import mailbox_pkg::*;

    // ------------------------------------------------------------------
    // Signals and expected state
    // ------------------------------------------------------------------
    logic              i_ref_clk, i_rst, clk_a, clk_b, oe_a, oe_b;
    logic              full_ab_n, full_ba_n, exp_ab_f, exp_ba_f;
    port_in_t          pins_a, pins_b;
    logic [MAIL_W-1:0] bus_a, bus_b, fifo_q, exp_ab, exp_ba, d, e;
    logic [31:0]       rng_q, w;
    int                n_mismatch, checked;

    dual_port_mailbox_bypass i_dual_port_mailbox_bypass (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_port_a_clock(clk_a), .i_port_a(pins_a),
        .o_port_a_data_bus(bus_a), .o_port_a_data_oe(oe_a),
        .o_b_to_a_mail_full_n(full_ba_n),
        .i_port_b_clock(clk_b), .i_port_b(pins_b),
        .o_port_b_data_bus(bus_b), .o_port_b_data_oe(oe_b),
        .o_a_to_b_mail_full_n(full_ab_n), .i_fifo_out_data(fifo_q));
    mailbox_host_model #(.HALF_NS(20.0)) i_mailbox_host_model_a (
        .i_ref_clk(i_ref_clk), .o_port_clk(clk_a), .o_port(pins_a));
    mailbox_host_model #(.HALF_NS(25.0)) i_mailbox_host_model_b (
        .i_ref_clk(i_ref_clk), .o_port_clk(clk_b), .o_port(pins_b));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q;
    endfunction

    // Next full flag: an accepted write wins over a consuming read.
    function automatic logic exp_full_n(logic f, logic wr, logic rd);
        if (wr && f) return 1'h0;
        return rd ? 1'h1 : f;
    endfunction

    function automatic port_in_t pin(logic c, logic wr, logic en, logic mb,
                                     logic [MAIL_W-1:0] dv);
        return '{c, wr, en, mb, dv};
    endfunction

    task automatic cmp_bit(input string nm, input logic x, input logic g);
        checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic cmp_word(input string nm, input logic [MAIL_W-1:0] x,
                            input logic [MAIL_W-1:0] g);
        checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Compares both flags, both enables and each data bus while driven against the expected state and held pins.
    task automatic check_all();
        cmp_bit("full_ab_n", exp_ab_f, full_ab_n);
        cmp_bit("full_ba_n", exp_ba_f, full_ba_n);
        cmp_bit("oe_a", !pins_a.cs_n && !pins_a.wr_rd, oe_a);
        cmp_bit("oe_b", !pins_b.cs_n && pins_b.wr_rd, oe_b);
        if (oe_a === 1'h1) cmp_word("bus_a", exp_ba, bus_a);
        if (oe_b === 1'h1)
            cmp_word("bus_b", pins_b.mb ? exp_ab : fifo_q, bus_b);
    endtask

    // One transfer edge with enable high, then pins held with enable low.
    task automatic op(input bit on_b, input port_in_t p);
        logic wr, rd;
        wr = !p.cs_n && p.en && p.mb && (p.wr_rd ^ on_b);
        rd = !p.cs_n && p.en && p.mb && !(p.wr_rd ^ on_b);
        if (on_b) begin
            if (wr && exp_ba_f) exp_ba = p.data;
            exp_ba_f = exp_full_n(exp_ba_f, wr, 1'h0);
            exp_ab_f = exp_full_n(exp_ab_f, 1'h0, rd);
            i_mailbox_host_model_b.set_pins(p);
            p.en = 1'h0;
            i_mailbox_host_model_b.set_pins(p);
        end else begin
            if (wr && exp_ab_f) exp_ab = p.data;
            exp_ab_f = exp_full_n(exp_ab_f, wr, 1'h0);
            exp_ba_f = exp_full_n(exp_ba_f, 1'h0, rd);
            i_mailbox_host_model_a.set_pins(p);
            p.en = 1'h0;
            i_mailbox_host_model_a.set_pins(p);
        end
        repeat (5) @(negedge i_ref_clk);
        check_all();
    endtask

    task automatic finish_test();
        $display("Checks: %0d, mismatches: %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        i_ref_clk = 1'h0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    // Cuts a hang short; the full run needs about 8 us.
    initial begin
        #80000;
        n_mismatch++;
        finish_test();
    end

    // Random rounds; the first round uses an all-ones corner word.
    initial begin
        i_rst = 1'h1;
        rng_q = 32'hC370;
        fifo_q = MAIL_RESET;
        {n_mismatch, checked} = '0;
        {exp_ab, exp_ba} = {MAIL_RESET, MAIL_RESET};
        {exp_ab_f, exp_ba_f} = {FULL_N_RESET, FULL_N_RESET};
        repeat (6) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'h0;
        repeat (8) @(negedge i_ref_clk);
        check_all();
        for (int r = 0; r < 8; r++) begin
            w = xorshift();
            d = (r == 0) ? {MAIL_W{1'h1}} : {w[3:0], xorshift()};
            w = xorshift();
            e = {w[3:0], xorshift()};
            fifo_q = ~e;
            op(0, pin(1'h0, 1'h1, 1'h1, 1'h1, d));
            op(0, pin(1'h0, 1'h1, 1'h1, 1'h1, ~d));
            op(1, pin(1'h0, 1'h1, 1'h0, 1'h1, e));
            op(1, pin(1'h0, 1'h1, 1'h1, 1'h0, e));
            op(1, pin(1'h0, 1'h1, 1'h1, 1'h1, e));
            op(0, pin(r % 3 == 0, 1'h1, r % 3 != 1, r % 3 != 2, e));
            op(1, pin(1'h0, 1'h0, 1'h1, 1'h1, e));
            op(1, pin(1'h0, 1'h0, 1'h1, 1'h1, d));
            op(0, pin(1'h0, 1'h0, 1'h1, 1'h0, d));
            op(0, pin(1'h0, 1'h0, 1'h1, 1'h1, d));
            op(0, pin(1'h1, 1'h0, 1'h0, 1'h0, ~d));
        end
        finish_test();
    end
endmodule
